/* logic/rvs_pkg.sv */
package rvs_pkg;
	// register offsets
	localparam logic [7:0] ADDR_REVISION = 8'h00;
	localparam logic [7:0] ADDR_BUCK_ONE = 8'h01;
	localparam logic [7:0] ADDR_BUCK_TWO_LDO = 8'h02;
	// field positions
	localparam int MAJ_HI = 7;
	localparam int MAJ_LO = 5;
	localparam int MIN_HI = 4;
	localparam int MIN_LO = 2;
	localparam int OPT_HI = 1;
	localparam int OPT_LO = 0;
	localparam int B1_HI = 2;
	localparam int B1_LO = 0;
	localparam int B2_HI = 7;
	localparam int B2_LO = 4;
	localparam int LDO_HI = 3;
	localparam int LDO_LO = 0;
	localparam logic [7:0] ZERO_BYTE = 8'h00;
	localparam logic [4:0] RSV_ZERO = 5'h00;
	// bus constants
	localparam logic [6:0] SLAVE_ADDR = 7'h14;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [3:0] LAST_BIT = 4'h7;
	// voltage map, millivolts
	localparam logic [2:0] B1_RESERVED_CODE = 3'h7;
	localparam logic [11:0] B2_FLOOR_MV = 12'h44C;
	localparam logic [11:0] B2_KNEE_CODE = 12'h009;
	localparam logic [11:0] B2_KNEE_MV = 12'h4B0;
	localparam logic [11:0] LDO_BASE_MV = 12'h708;
	localparam logic [11:0] STEP_MV = 12'h064;

	typedef enum logic [3:0] {
		RVS_IDLE = 4'h0,
		RVS_ADDR = 4'h1,
		RVS_ADDR_ACK = 4'h2,
		RVS_PTR = 4'h3,
		RVS_PTR_ACK = 4'h4,
		RVS_WDATA = 4'h5,
		RVS_WDATA_ACK = 4'h6,
		RVS_RDATA = 4'h7,
		RVS_RACK = 4'h8
	} rvs_state_e;

	function automatic logic [11:0] rvs_b1_mv(input logic [2:0] code);
		case (code)
			3'h0: rvs_b1_mv = 12'h9C4;
			3'h1: rvs_b1_mv = 12'hAF0;
			3'h2: rvs_b1_mv = 12'hB54;
			3'h3: rvs_b1_mv = 12'hBB8;
			3'h4: rvs_b1_mv = 12'hC80;
			3'h5: rvs_b1_mv = 12'hCE4;
			3'h6: rvs_b1_mv = 12'hE74;
			default: rvs_b1_mv = 12'h000;
		endcase
	endfunction : rvs_b1_mv

	function automatic logic [11:0] rvs_b2_mv(input logic [3:0] code);
		if ({8'h00, code} < B2_KNEE_CODE) begin
			rvs_b2_mv = B2_FLOOR_MV;
		end else begin
			rvs_b2_mv = B2_KNEE_MV + ({8'h00, code} - B2_KNEE_CODE) * STEP_MV;
		end
	endfunction : rvs_b2_mv

	function automatic logic [11:0] rvs_ldo_mv(input logic [3:0] code);
		rvs_ldo_mv = LDO_BASE_MV + {8'h00, code} * STEP_MV;
	endfunction : rvs_ldo_mv
endpackage : rvs_pkg

/* logic/rvs_regs.sv */
`timescale 1ns/1ps
module rvs_regs #(
	parameter logic [2:0] MAJOR = 3'h1, // arbitrary
	parameter logic [2:0] MINOR = 3'h0, // arbitrary
	parameter logic [1:0] OPTION = 2'h0 // arbitrary
) (
	// clock and reset
	input wire logic clock,
	input wire logic reset,
	// fuse values, loaded at reset
	input wire logic [2:0] fuse_first_buck_code,
	input wire logic [3:0] fuse_second_buck_code,
	input wire logic [3:0] fuse_linear_code,
	// access from the serial engine
	input wire logic wr_en,
	input wire logic [7:0] wr_addr,
	input wire logic [7:0] wr_data,
	input wire logic [7:0] rd_addr,
	output logic [7:0] rd_data,
	// regulator settings
	output logic [2:0] first_buck_voltage_code,
	output logic [3:0] second_buck_voltage_code,
	output logic [3:0] linear_regulator_voltage_code,
	output logic [11:0] first_buck_mv,
	output logic [11:0] second_buck_mv,
	output logic [11:0] linear_mv
);
	typedef struct packed {
		logic [2:0] b1;
		logic [3:0] b2;
		logic [3:0] ldo;
		logic [11:0] b1_mv;
		logic [11:0] b2_mv;
		logic [11:0] ldo_mv;
	} rvs_regs_s;

	rvs_regs_s s_ff, nxt_s;

	always_comb begin
		nxt_s = s_ff;
		if (reset) begin
			nxt_s.b1 = fuse_first_buck_code;
			nxt_s.b2 = fuse_second_buck_code;
			nxt_s.ldo = fuse_linear_code;
		end else if (wr_en) begin
			case (wr_addr)
				rvs_pkg::ADDR_BUCK_ONE: begin
					// reserved code would select no defined level
					if (wr_data[rvs_pkg::B1_HI:rvs_pkg::B1_LO] !=
						rvs_pkg::B1_RESERVED_CODE) begin
						nxt_s.b1 = wr_data[rvs_pkg::B1_HI:rvs_pkg::B1_LO];
					end
				end
				rvs_pkg::ADDR_BUCK_TWO_LDO: begin
					nxt_s.b2 = wr_data[rvs_pkg::B2_HI:rvs_pkg::B2_LO];
					nxt_s.ldo = wr_data[rvs_pkg::LDO_HI:rvs_pkg::LDO_LO];
				end
				default: begin
					nxt_s.b1 = s_ff.b1;
				end
			endcase
		end
		nxt_s.b1_mv = rvs_pkg::rvs_b1_mv(nxt_s.b1);
		nxt_s.b2_mv = rvs_pkg::rvs_b2_mv(nxt_s.b2);
		nxt_s.ldo_mv = rvs_pkg::rvs_ldo_mv(nxt_s.ldo);
	end

	always_ff @(posedge clock) begin
		s_ff <= nxt_s;
	end

	always_comb begin
		case (rd_addr)
			rvs_pkg::ADDR_REVISION: rd_data = {MAJOR, MINOR, OPTION};
			rvs_pkg::ADDR_BUCK_ONE: rd_data = {rvs_pkg::RSV_ZERO, s_ff.b1};
			rvs_pkg::ADDR_BUCK_TWO_LDO: rd_data = {s_ff.b2, s_ff.ldo};
			default: rd_data = rvs_pkg::ZERO_BYTE;
		endcase
	end

	assign first_buck_voltage_code = s_ff.b1;
	assign second_buck_voltage_code = s_ff.b2;
	assign linear_regulator_voltage_code = s_ff.ldo;
	assign first_buck_mv = s_ff.b1_mv;
	assign second_buck_mv = s_ff.b2_mv;
	assign linear_mv = s_ff.ldo_mv;

	property p_rev;
		@(posedge clock) disable iff (reset)
		rd_addr == rvs_pkg::ADDR_REVISION |->
			rd_data[rvs_pkg::MAJ_HI:rvs_pkg::MAJ_LO] == MAJOR &&
			rd_data[rvs_pkg::MIN_HI:rvs_pkg::MIN_LO] == MINOR &&
			rd_data[rvs_pkg::OPT_HI:rvs_pkg::OPT_LO] == OPTION;
	endproperty
	a_rev: assert property (p_rev) else $error("revision read wrong");

	property p_fuse;
		@(posedge clock)
		reset ##1 !reset |-> first_buck_voltage_code ==
			$past(fuse_first_buck_code, 1);
	endproperty
	a_fuse: assert property (p_fuse) else $error("fuse not loaded");

	property p_b1_rsv;
		@(posedge clock) disable iff (reset)
		wr_en && wr_addr == rvs_pkg::ADDR_BUCK_ONE &&
			wr_data[rvs_pkg::B1_HI:rvs_pkg::B1_LO] ==
			rvs_pkg::B1_RESERVED_CODE |=>
			$stable(first_buck_voltage_code);
	endproperty
	a_b1_rsv: assert property (p_b1_rsv) else $error("reserved code stored");

	property p_wr2;
		@(posedge clock) disable iff (reset)
		wr_en && wr_addr == rvs_pkg::ADDR_BUCK_TWO_LDO |=>
			{second_buck_voltage_code, linear_regulator_voltage_code} ==
			$past(wr_data);
	endproperty
	a_wr2: assert property (p_wr2) else $error("combined write lost");

	property p_b2_mv;
		@(posedge clock) disable iff (reset)
		second_buck_voltage_code <= 4'h8 |-> second_buck_mv == 12'h44C;
	endproperty
	a_b2_mv: assert property (p_b2_mv) else $error("second buck floor");

	property p_ldo_mv;
		@(posedge clock) disable iff (reset)
		linear_regulator_voltage_code == 4'hF |-> linear_mv == 12'hCE4;
	endproperty
	a_ldo_mv: assert property (p_ldo_mv) else $error("ldo top level");

	property p_rsv_zero;
		@(posedge clock) disable iff (reset)
		rd_addr == rvs_pkg::ADDR_BUCK_ONE |-> rd_data[7:3] == 5'h00;
	endproperty
	a_rsv_zero: assert property (p_rsv_zero) else $error("reserved bits set");
endmodule : rvs_regs

/* logic/rvs_i2c_regs.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - revision register bits 7:5 major, 4:2 minor, read only
// - revision bits 1:0 hold read-only family option code
// - first buck code bits 2:0 read/write, fuse loaded, bits 7:3 reserved
// - first buck codes map 2.5 to 3.7 V; code 111 reserved
// - second buck code bits 7:4 of combined register, fuse loaded, writable
// - second buck codes up to 1000 give 1.1 V, then 0.1 V steps
// - linear regulator code bits 3:0 of combined register, fuse loaded
// - linear regulator 1.8 V at code 0, 0.1 V per step
// - registers reached as I2C slave at 100 or 400 kHz
// - after start, seven-bit address then direction bit, one means read
module rvs_i2c_regs #(
	parameter logic [2:0] MAJOR = 3'h1, // arbitrary
	parameter logic [2:0] MINOR = 3'h0, // arbitrary
	parameter logic [1:0] OPTION = 2'h0 // arbitrary
) (
	// clock and reset
	input wire logic clock,
	input wire logic reset,
	// serial bus pins
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	// fuse values
	input wire logic [2:0] fuse_first_buck_code,
	input wire logic [3:0] fuse_second_buck_code,
	input wire logic [3:0] fuse_linear_code,
	// regulator settings
	output logic [2:0] first_buck_voltage_code,
	output logic [3:0] second_buck_voltage_code,
	output logic [3:0] linear_regulator_voltage_code,
	output logic [11:0] first_buck_mv,
	output logic [11:0] second_buck_mv,
	output logic [11:0] linear_mv
);
	typedef struct packed {
		logic scl_s1;
		logic scl_s2;
		logic scl_q;
		logic sda_s1;
		logic sda_s2;
		logic sda_q;
		rvs_pkg::rvs_state_e st;
		logic [3:0] cnt;
		logic [7:0] sh;
		logic [7:0] ptr;
		logic rd;
		logic mack;
		logic oe;
	} rvs_link_s;

	rvs_link_s s_ff, nxt_s;
	logic rise, fall, start, stop;
	logic wr_en;
	logic [7:0] rd_data;

	// 40 MHz oversamples even fast-mode scl by a factor of 100
	assign rise = s_ff.scl_s2 & ~s_ff.scl_q;
	assign fall = ~s_ff.scl_s2 & s_ff.scl_q;
	assign start = s_ff.scl_s2 & s_ff.sda_q & ~s_ff.sda_s2;
	assign stop = s_ff.scl_s2 & ~s_ff.sda_q & s_ff.sda_s2;

	always_comb begin
		nxt_s = s_ff;
		wr_en = 1'b0;
		nxt_s.scl_s1 = scl_in;
		nxt_s.scl_s2 = s_ff.scl_s1;
		nxt_s.scl_q = s_ff.scl_s2;
		nxt_s.sda_s1 = sda_in;
		nxt_s.sda_s2 = s_ff.sda_s1;
		nxt_s.sda_q = s_ff.sda_s2;
		if (start) begin
			nxt_s.st = rvs_pkg::RVS_ADDR;
			nxt_s.cnt = 4'h0;
			nxt_s.oe = 1'b0;
		end else if (stop) begin
			nxt_s.st = rvs_pkg::RVS_IDLE;
			nxt_s.oe = 1'b0;
		end else begin
			case (s_ff.st)
				rvs_pkg::RVS_ADDR, rvs_pkg::RVS_PTR, rvs_pkg::RVS_WDATA: begin
					if (rise) begin
						nxt_s.sh = {s_ff.sh[6:0], s_ff.sda_s2};
						nxt_s.cnt = s_ff.cnt + 4'h1;
					end else if (fall && s_ff.cnt == rvs_pkg::BITS_PER_BYTE) begin
						nxt_s.oe = 1'b1;
						if (s_ff.st == rvs_pkg::RVS_ADDR) begin
							// a foreign address leaves the bus alone
							if (s_ff.sh[7:1] == rvs_pkg::SLAVE_ADDR) begin
								nxt_s.rd = s_ff.sh[0];
								nxt_s.st = rvs_pkg::RVS_ADDR_ACK;
							end else begin
								nxt_s.oe = 1'b0;
								nxt_s.st = rvs_pkg::RVS_IDLE;
							end
						end else if (s_ff.st == rvs_pkg::RVS_PTR) begin
							nxt_s.ptr = s_ff.sh;
							nxt_s.st = rvs_pkg::RVS_PTR_ACK;
						end else begin
							wr_en = 1'b1;
							nxt_s.ptr = s_ff.ptr + 8'h01;
							nxt_s.st = rvs_pkg::RVS_WDATA_ACK;
						end
					end
				end
				rvs_pkg::RVS_ADDR_ACK: begin
					if (fall) begin
						nxt_s.cnt = 4'h0;
						if (s_ff.rd) begin
							nxt_s.sh = rd_data;
							nxt_s.oe = ~rd_data[7];
							nxt_s.st = rvs_pkg::RVS_RDATA;
						end else begin
							nxt_s.oe = 1'b0;
							nxt_s.st = rvs_pkg::RVS_PTR;
						end
					end
				end
				rvs_pkg::RVS_PTR_ACK, rvs_pkg::RVS_WDATA_ACK: begin
					if (fall) begin
						nxt_s.oe = 1'b0;
						nxt_s.cnt = 4'h0;
						nxt_s.st = rvs_pkg::RVS_WDATA;
					end
				end
				rvs_pkg::RVS_RDATA: begin
					if (fall) begin
						if (s_ff.cnt == rvs_pkg::LAST_BIT) begin
							nxt_s.oe = 1'b0;
							nxt_s.ptr = s_ff.ptr + 8'h01;
							nxt_s.st = rvs_pkg::RVS_RACK;
						end else begin
							nxt_s.sh = {s_ff.sh[6:0], 1'b0};
							nxt_s.oe = ~s_ff.sh[6];
							nxt_s.cnt = s_ff.cnt + 4'h1;
						end
					end
				end
				rvs_pkg::RVS_RACK: begin
					if (rise) begin
						nxt_s.mack = ~s_ff.sda_s2;
					end else if (fall) begin
						// a missing acknowledge ends the read burst
						if (s_ff.mack) begin
							nxt_s.sh = rd_data;
							nxt_s.oe = ~rd_data[7];
							nxt_s.cnt = 4'h0;
							nxt_s.st = rvs_pkg::RVS_RDATA;
						end else begin
							nxt_s.st = rvs_pkg::RVS_IDLE;
						end
					end
				end
				default: begin
					nxt_s.oe = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			s_ff <= '{scl_s1: 1'b1, scl_s2: 1'b1, scl_q: 1'b1,
				sda_s1: 1'b1, sda_s2: 1'b1, sda_q: 1'b1,
				st: rvs_pkg::RVS_IDLE, cnt: 4'h0, sh: 8'h00, ptr: 8'h00,
				rd: 1'b0, mack: 1'b0, oe: 1'b0};
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign sda_out = 1'b0;
	assign sda_oe = s_ff.oe;

	rvs_regs #(
		.MAJOR(MAJOR),
		.MINOR(MINOR),
		.OPTION(OPTION)
	) u_regs (
		.clock(clock),
		.reset(reset),
		.fuse_first_buck_code(fuse_first_buck_code),
		.fuse_second_buck_code(fuse_second_buck_code),
		.fuse_linear_code(fuse_linear_code),
		.wr_en(wr_en),
		.wr_addr(s_ff.ptr),
		.wr_data(s_ff.sh),
		.rd_addr(s_ff.ptr),
		.rd_data(rd_data),
		.first_buck_voltage_code(first_buck_voltage_code),
		.second_buck_voltage_code(second_buck_voltage_code),
		.linear_regulator_voltage_code(linear_regulator_voltage_code),
		.first_buck_mv(first_buck_mv),
		.second_buck_mv(second_buck_mv),
		.linear_mv(linear_mv)
	);

	sequence s_addr_done;
		s_ff.st == rvs_pkg::RVS_ADDR && fall &&
			s_ff.cnt == rvs_pkg::BITS_PER_BYTE;
	endsequence

	sequence s_match;
		s_ff.sh[7:1] == rvs_pkg::SLAVE_ADDR;
	endsequence

	property p_ack_match;
		@(posedge clock) disable iff (reset)
		s_addr_done and s_match |=> sda_oe &&
			s_ff.st == rvs_pkg::RVS_ADDR_ACK;
	endproperty
	a_ack_match: assert property (p_ack_match) else $error("no address ack");

	property p_no_foreign;
		@(posedge clock) disable iff (reset)
		s_addr_done and s_ff.sh[7:1] != rvs_pkg::SLAVE_ADDR |=> !sda_oe;
	endproperty
	a_no_foreign: assert property (p_no_foreign) else $error("foreign ack");

	property p_dir;
		@(posedge clock) disable iff (reset)
		s_ff.st == rvs_pkg::RVS_ADDR_ACK && fall && !start && !stop |=>
			(s_ff.st == rvs_pkg::RVS_RDATA) == $past(s_ff.rd);
	endproperty
	a_dir: assert property (p_dir) else $error("direction bit ignored");

	// one shift pulse per synchronised scl rise, never a stretched one
	property p_sync;
		@(posedge clock) disable iff (reset)
		$rose(s_ff.scl_s2) |-> rise ##1 !rise;
	endproperty
	a_sync: assert property (p_sync) else $error("scl edge missed");
endmodule : rvs_i2c_regs

/* sim/rvs_i2c_master.sv */
`timescale 1ns/1ps
module rvs_i2c_master #(
	parameter int QTR = 25
) (
	// clock
	input wire logic clock,
	// bus lines
	input wire logic sda,
	output logic scl,
	output logic sda_pull,
	// read results
	output logic rd_valid,
	output logic [7:0] rd_byte
);
	initial begin
		scl = 1'b1;
		sda_pull = 1'b0;
		rd_valid = 1'b0;
		rd_byte = 8'h00;
	end

	// a quarter bit is 25 clocks, so one bit lasts 100 clocks: 400 kHz
	task automatic qtr();
		repeat (QTR) @(negedge clock);
	endtask : qtr

	// also serves as repeated start, entered with scl low
	task automatic start_cond();
		sda_pull = 1'b0;
		qtr();
		scl = 1'b1;
		qtr();
		sda_pull = 1'b1;
		qtr();
		scl = 1'b0;
		qtr();
	endtask : start_cond

	task automatic stop_cond();
		sda_pull = 1'b1;
		qtr();
		scl = 1'b1;
		qtr();
		sda_pull = 1'b0;
		qtr();
		qtr();
	endtask : stop_cond

	// data changes only while scl is low; sampled in mid high phase
	task automatic bit_cyc(input logic b, output logic s);
		sda_pull = !b;
		qtr();
		scl = 1'b1;
		qtr();
		s = sda;
		qtr();
		scl = 1'b0;
		qtr();
	endtask : bit_cyc

	task automatic send_byte(input logic [7:0] d, output logic nack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_cyc(d[i], s);
		end
		bit_cyc(1'b1, nack);
	endtask : send_byte

	// seven-bit address, then direction bit zero for a write
	task automatic write(input logic [6:0] dev, input logic [7:0] ptr,
		input logic [15:0] data, input int n, output logic [3:0] nk);
		nk = 4'h0;
		start_cond();
		send_byte({dev, 1'b0}, nk[3]);
		send_byte(ptr, nk[2]);
		send_byte(data[15:8], nk[1]);
		if (n > 1) begin
			send_byte(data[7:0], nk[0]);
		end
		stop_cond();
	endtask : write

	task automatic read(input logic [7:0] ptr, input int n,
		output logic [3:0] nk);
		logic [7:0] d;
		logic s;
		nk = 4'h0;
		start_cond();
		send_byte({rvs_pkg::SLAVE_ADDR, 1'b0}, nk[3]);
		send_byte(ptr, nk[2]);
		start_cond();
		send_byte({rvs_pkg::SLAVE_ADDR, 1'b1}, nk[1]);
		for (int k = 0; k < n; k++) begin
			for (int i = 7; i >= 0; i--) begin
				bit_cyc(1'b1, d[i]);
			end
			bit_cyc(k == n - 1, s);
			rd_byte = d;
			rd_valid = 1'b1;
			@(negedge clock);
			rd_valid = 1'b0;
		end
		stop_cond();
	endtask : read
endmodule : rvs_i2c_master

/* sim/rvs_testbench.sv */
`timescale 1ns/1ps
module testbench;
	localparam logic [2:0] T_MAJOR = 3'h5; // arbitrary
	localparam logic [2:0] T_MINOR = 3'h3; // arbitrary
	localparam logic [1:0] T_OPTION = 2'h2; // arbitrary
	logic clock = 1'b0;
	logic reset = 1'b1;
	logic scl, sda, sda_pull, rd_valid, sda_out, sda_oe;
	logic [7:0] rd_byte;
	logic [2:0] f1 = 3'h0;
	logic [3:0] f2 = 4'h0;
	logic [3:0] f3 = 4'h0;
	logic [2:0] c1;
	logic [3:0] c2, c3;
	logic [11:0] mv1, mv2, mv3;
	logic [3:0] nk;
	logic [7:0] exp_q[$];
	int n_errors = 0;
	int n_checks = 0;
	int seed = 35003;

	always #12.5 clock = ~clock;
	// pull-up wire: released by both parties it reads high
	assign sda = sda_pull ? 1'b0 : (sda_oe ? sda_out : 1'b1);

	rvs_i2c_master m (.clock(clock), .sda(sda), .scl(scl),
		.sda_pull(sda_pull), .rd_valid(rd_valid), .rd_byte(rd_byte));
	rvs_i2c_regs #(.MAJOR(T_MAJOR), .MINOR(T_MINOR), .OPTION(T_OPTION)) dut (
		.clock(clock), .reset(reset), .scl_in(scl), .sda_in(sda),
		.sda_out(sda_out), .sda_oe(sda_oe),
		.fuse_first_buck_code(f1), .fuse_second_buck_code(f2),
		.fuse_linear_code(f3), .first_buck_voltage_code(c1),
		.second_buck_voltage_code(c2), .linear_regulator_voltage_code(c3),
		.first_buck_mv(mv1), .second_buck_mv(mv2), .linear_mv(mv3));

	task automatic give_verdict();
		$display("errors %0d checks %0d", n_errors, n_checks);
		if (n_errors == 0 && n_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : give_verdict

	task automatic check(input logic [11:0] seen, input logic [11:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	function automatic logic [11:0] exp_b1(input logic [2:0] c);
		logic [11:0] t [7] = '{12'h9C4, 12'hAF0, 12'hB54, 12'hBB8,
			12'hC80, 12'hCE4, 12'hE74};
		exp_b1 = t[c];
	endfunction : exp_b1

	task automatic check_codes(input logic [2:0] e1, input logic [3:0] e2,
		input logic [3:0] e3);
		logic [11:0] e_b2;
		// codes up to 8 sit on the floor, then 100 mV per step
		e_b2 = (e2 < 4'h9) ? 12'd1100 :
			12'd1200 + 12'd100 * {8'h00, e2 - 4'h9};
		check({9'h000, c1}, {9'h000, e1});
		check({8'h00, c2}, {8'h00, e2});
		check({8'h00, c3}, {8'h00, e3});
		check(mv1, exp_b1(e1));
		check(mv2, e_b2);
		check(mv3, 12'd1800 + 12'd100 * e3);
	endtask : check_codes

	task automatic do_reset();
		f1 = 3'($unsigned($random(seed)) % 7);
		f2 = 4'($random(seed));
		f3 = 4'($random(seed));
		reset = 1'b1;
		repeat (20) @(negedge clock);
		reset = 1'b0;
		repeat (8) @(negedge clock);
		check_codes(f1, f2, f3);
	endtask : do_reset

	// each read byte is compared with the oldest note
	always @(posedge clock) begin
		if (rd_valid === 1'b1) begin
			if (exp_q.size() == 0) begin
				check({4'h0, rd_byte}, 12'hFFF);
			end else begin
				check({4'h0, rd_byte}, {4'h0, exp_q.pop_front()});
			end
		end
	end

	// bounded run: a hang counts as a mismatch
	initial begin
		repeat (100000) @(posedge clock);
		n_errors++;
		give_verdict();
	end

	initial begin
		logic [2:0] e1;
		e1 = 3'h0;
		do_reset();
		exp_q.push_back({T_MAJOR, T_MINOR, T_OPTION});
		m.read(8'h00, 1, nk);
		check({8'h00, nk}, 12'h000);
		// reserved bits set, code 7 must leave the previous code
		for (int k = 0; k < 16; k++) begin
			if (k % 8 != 7) begin
				e1 = 3'(k % 8);
			end
			m.write(rvs_pkg::SLAVE_ADDR, 8'h01,
				{5'h15, 3'(k % 8), 4'(k), 4'(15 - k)}, 2, nk);
			check({8'h00, nk}, 12'h000);
			check_codes(e1, 4'(k), 4'(15 - k));
		end
		exp_q.push_back({T_MAJOR, T_MINOR, T_OPTION});
		exp_q.push_back(8'h06);
		exp_q.push_back(8'hF0);
		exp_q.push_back(8'h00);
		m.read(8'h00, 4, nk);
		check({8'h00, nk}, 12'h000);
		// another slave address is not acknowledged and changes nothing
		m.write(7'h15, 8'h02, 16'h5A5A, 1, nk);
		check({11'h000, nk[3]}, 12'h001);
		m.write(rvs_pkg::SLAVE_ADDR, 8'h00, 16'hFFFF, 1, nk);
		check({8'h00, nk}, 12'h000);
		exp_q.push_back({T_MAJOR, T_MINOR, T_OPTION});
		m.read(8'h00, 1, nk);
		check({8'h00, nk}, 12'h000);
		check_codes(3'h6, 4'hF, 4'h0);
		do_reset();
		give_verdict();
	end
endmodule : testbench
